// [clk_ctrl_pkg.sv]
// Purpose: shared constants and carriers for the clock select block
// Assumes: one core clock at 100 MHz
// Notes: codes and reset values of the clock control bits
package clk_ctrl_pkg;

  localparam int CLK_FREQ_MHZ = 100;
  // stop detector: main clock must toggle within this window
  localparam int DETECT_WINDOW_NS = 1000;
  localparam int DETECT_WINDOW_CYC = (DETECT_WINDOW_NS * CLK_FREQ_MHZ) / 1000;
  localparam int DETECT_CNT_W = 8;

  // cpu divider codes
  localparam logic [1:0] DIV_CODE_1 = 2'h0;
  localparam logic [1:0] DIV_CODE_2 = 2'h1;
  localparam logic [1:0] DIV_CODE_4 = 2'h2;
  localparam logic [1:0] DIV_CODE_16 = 2'h3;
  localparam logic [4:0] DIV_RATIO_1 = 5'h01;
  localparam logic [4:0] DIV_RATIO_2 = 5'h02;
  localparam logic [4:0] DIV_RATIO_4 = 5'h04;
  localparam logic [4:0] DIV_RATIO_8 = 5'h08;
  localparam logic [4:0] DIV_RATIO_16 = 5'h10;

  // reset values
  localparam logic RST_SUB_OSC_ENABLE = 1'b0;
  localparam logic RST_MAIN_OSC_STOP = 1'b0;
  localparam logic RST_DIV8_SELECT = 1'b1;
  localparam logic [1:0] RST_DIV_CODE = 2'h0;

  typedef enum logic [1:0]
  {
    SRC_MAIN = 2'b00,
    SRC_PLL = 2'b01,
    SRC_ONCHIP = 2'b10,
    SRC_SUB = 2'b11
  } clk_src_e;

  typedef enum logic [1:0]
  {
    PWR_RUN = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_STOP = 2'b10
  } pwr_state_e;

  // software write to the clock control bits
  typedef struct packed
  {
    logic subOscEnable;
    logic mainOscStop;
    logic div8Select;
    logic subClockSelect;
    logic waitPeriphClockStop;
    logic [1:0] cpuDivCode;
    logic allClockStop;
    logic pllSourceSelect;
    logic stopDetectEnable;
    logic onchipOscSelect;
    logic stopDetectedFlag;
    logic detectActionSelect;
    logic pllCtrlEnable;
    logic clockModLock;
  } clk_ctrl_s;

  // clock selection result
  typedef struct packed
  {
    clk_src_e cpuSource;
    clk_src_e periphSource;
    logic [4:0] cpuDivRatio;
    logic onchipOscRun;
  } clk_sel_s;

endpackage

// [osc_stop_detector.sv]
// Purpose: sees whether the main oscillator toggles
// Assumes: main clock sample is asynchronous to core_clk
// Notes: a stopped oscillator is one that holds level for the window
`timescale 1ns/10ps
module osc_stop_detector
#(
  parameter int WINDOW_CYC = clk_ctrl_pkg::DETECT_WINDOW_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // oscillator sample
  input wire logic mainClkSample,
  // result
  output logic mainRunning
);
  import clk_ctrl_pkg::*;

  logic [2:0] syncReg;
  logic [DETECT_CNT_W-1:0] idleReg;
  logic mainRunningReg;

  //////////////////////////////////////////////////////////////////
  // three-stage sync; only stages two and three are compared
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      syncReg <= 3'h0;
    else
      syncReg <= {syncReg[1:0], mainClkSample};
  end

  // edge restarts the window; expiry marks the oscillator stopped
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idleReg <= '0;
      mainRunningReg <= 1'b1;
    end
    else if (syncReg[2] != syncReg[1])
    begin
      idleReg <= '0;
      mainRunningReg <= 1'b1;
    end
    else if (idleReg >= DETECT_CNT_W'(WINDOW_CYC - 1))
      mainRunningReg <= 1'b0;
    else
      idleReg <= idleReg + DETECT_CNT_W'(1);
  end

  assign mainRunning = mainRunningReg;
endmodule

// [clock_select_osc_stop_detect.sv]
// Purpose: clock source select, cpu divider, power modes, oscillator stop detect
// Assumes: software bits arrive as write strobes with data; one clock domain
// Notes: the stop reset output halts the device until a hardware reset
`timescale 1ns/10ps
module clock_select_osc_stop_detect
#(
  parameter int WINDOW_CYC = clk_ctrl_pkg::DETECT_WINDOW_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // software writes: ctrlWrite for the control bits, lockWrite for the lock bit, data alongside
  input wire logic ctrlWrite,
  input wire clk_ctrl_pkg::clk_ctrl_s ctrlData,
  input wire logic lockWrite,
  input wire logic waitInstr,
  input wire logic hwInterrupt,
  // oscillator status
  input wire logic mainClkSample,
  // watchdog interrupt to share the vector
  input wire logic watchdogIrq,
  // control state out
  output clk_ctrl_pkg::clk_ctrl_s ctrlState,
  output clk_ctrl_pkg::clk_sel_s clkSel,
  output logic subOscRun,
  output logic mainOscRun,
  output clk_ctrl_pkg::pwr_state_e pwrState,
  output logic mainStoppedFlag,
  // events
  output logic sharedIrq,
  output logic oscStopIrq,
  output logic oscStopReset
);
  import clk_ctrl_pkg::*;

  function automatic logic [4:0] divRatio(input logic div8, input logic [1:0] code);
    logic [4:0] r;
    r = DIV_RATIO_8;
    if (!div8)
    begin
      unique case (code)
        DIV_CODE_1: r = DIV_RATIO_1;
        DIV_CODE_2: r = DIV_RATIO_2;
        DIV_CODE_4: r = DIV_RATIO_4;
        DIV_CODE_16: r = DIV_RATIO_16;
      endcase
    end
    return r;
  endfunction

  logic subOscEnableReg, mainOscStopReg, div8SelectReg, subClockSelectReg;
  logic waitPeriphClockStopReg, allClockStopReg, pllSourceSelectReg;
  logic [1:0] cpuDivCodeReg;
  logic stopDetectEnableReg, onchipOscSelectReg, stopDetectedReg;
  logic mainStoppedReg, detectActionReg, pllCtrlEnableReg, clockModLockReg;
  logic periphOnchipReg, haltReg, irqPulseReg;
  pwr_state_e pwrReg, pwrNext;
  logic mainRunning, mainRunDlyReg, stopEvent, restartEvent, detectEvent;
  logic writeOpen, useMain, usePll;

  osc_stop_detector #(.WINDOW_CYC(WINDOW_CYC)) detector
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mainClkSample(mainClkSample),
    .mainRunning(mainRunning)
  );

  //////////////////////////////////////////////////////////////////
  // detection events
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      mainRunDlyReg <= 1'b1;
    else
      mainRunDlyReg <= mainRunning;
  end

  // a main clock turned off by software is not an event
  assign stopEvent = mainRunDlyReg && !mainRunning && !mainOscStopReg;
  assign restartEvent = !mainRunDlyReg && mainRunning;
  // reset mode ignores the detected mask; the whole device goes down
  assign detectEvent = stopDetectEnableReg && (stopEvent || restartEvent) &&
    (!stopDetectedReg || !detectActionReg);
  assign writeOpen = ctrlWrite && !clockModLockReg;
  assign useMain = !pllCtrlEnableReg && !pllSourceSelectReg;
  assign usePll = pllCtrlEnableReg && pllSourceSelectReg;

  //////////////////////////////////////////////////////////////////
  // unprotected bits
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      subOscEnableReg <= RST_SUB_OSC_ENABLE;
      div8SelectReg <= RST_DIV8_SELECT;
      cpuDivCodeReg <= RST_DIV_CODE;
      detectActionReg <= 1'b0;
    end
    else if (ctrlWrite)
    begin
      subOscEnableReg <= ctrlData.subOscEnable;
      div8SelectReg <= ctrlData.div8Select;
      cpuDivCodeReg <= ctrlData.cpuDivCode;
      detectActionReg <= ctrlData.detectActionSelect;
    end
    else if (pwrReg == PWR_STOP && hwInterrupt)
      div8SelectReg <= 1'b1;
  end

  // protected bits
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mainOscStopReg <= RST_MAIN_OSC_STOP;
      subClockSelectReg <= 1'b0;
      waitPeriphClockStopReg <= 1'b0;
      pllSourceSelectReg <= 1'b0;
      stopDetectEnableReg <= 1'b0;
      pllCtrlEnableReg <= 1'b0;
    end
    else if (writeOpen)
    begin
      mainOscStopReg <= ctrlData.mainOscStop;
      subClockSelectReg <= ctrlData.subClockSelect;
      waitPeriphClockStopReg <= ctrlData.waitPeriphClockStop;
      pllSourceSelectReg <= ctrlData.pllSourceSelect;
      stopDetectEnableReg <= ctrlData.stopDetectEnable;
      pllCtrlEnableReg <= ctrlData.pllCtrlEnable;
    end
  end

  // lock bit: set only, cleared by reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      clockModLockReg <= 1'b0;
    else if (lockWrite)
      clockModLockReg <= clockModLockReg | ctrlData.clockModLock;
  end

  //////////////////////////////////////////////////////////////////
  // on-chip select: software, or hardware on main-source stop
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      onchipOscSelectReg <= 1'b0;
    else if (detectEvent && detectActionReg && stopEvent && !subClockSelectReg &&
      !onchipOscSelectReg && useMain)
      onchipOscSelectReg <= 1'b1;
    else if (ctrlWrite)
      onchipOscSelectReg <= ctrlData.onchipOscSelect;
  end

  // peripheral clocks move to on-chip on a stop in interrupt mode, when both PLL bits are clear or the sub clock is selected
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      periphOnchipReg <= 1'b0;
    else if (detectEvent && detectActionReg && stopEvent && (useMain || subClockSelectReg))
      periphOnchipReg <= 1'b1;
    else if (ctrlWrite && !ctrlData.onchipOscSelect && mainRunning)
      periphOnchipReg <= 1'b0;
  end

  // detected flag: set wins over a software clear
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      stopDetectedReg <= 1'b0;
    else if (detectEvent && detectActionReg)
      stopDetectedReg <= 1'b1;
    else if (ctrlWrite && !ctrlData.stopDetectedFlag)
      stopDetectedReg <= 1'b0;
  end

  // stopped flag follows stop and restart
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      mainStoppedReg <= 1'b0;
    else if (detectEvent && detectActionReg)
      mainStoppedReg <= stopEvent;
  end

  // interrupt pulse, one cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      irqPulseReg <= 1'b0;
    else
      irqPulseReg <= detectEvent && detectActionReg;
  end

  // stop reset latches until hardware reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      haltReg <= 1'b0;
    else if (detectEvent && !detectActionReg)
      haltReg <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////
  // power modes
  always_comb
  begin
    pwrNext = pwrReg;
    unique case (pwrReg)
      PWR_RUN:
        if (writeOpen && ctrlData.allClockStop)
          pwrNext = PWR_STOP;
        else if (waitInstr)
          pwrNext = PWR_WAIT;
      PWR_WAIT:
        if (hwInterrupt)
          pwrNext = PWR_RUN;
      PWR_STOP:
        if (hwInterrupt)
          pwrNext = PWR_RUN;
      default:
        pwrNext = PWR_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pwrReg <= PWR_RUN;
    else
      pwrReg <= pwrNext;
  end

  // all-clock-stop reads back as the stop state
  assign allClockStopReg = (pwrReg == PWR_STOP);

  //////////////////////////////////////////////////////////////////
  // clock selection; held in flops for clean data outputs
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      clkSel <= '{cpuSource: SRC_MAIN, periphSource: SRC_MAIN, cpuDivRatio: DIV_RATIO_8,
        onchipOscRun: 1'b0};
    else
    begin
      if (subClockSelectReg)
        clkSel.cpuSource <= SRC_SUB;
      else if (onchipOscSelectReg)
        clkSel.cpuSource <= SRC_ONCHIP;
      else if (usePll)
        clkSel.cpuSource <= SRC_PLL;
      else
        clkSel.cpuSource <= SRC_MAIN;
      clkSel.periphSource <= (periphOnchipReg || onchipOscSelectReg) ? SRC_ONCHIP :
        (usePll ? SRC_PLL : SRC_MAIN);
      clkSel.cpuDivRatio <= divRatio(div8SelectReg, cpuDivCodeReg);
      clkSel.onchipOscRun <= onchipOscSelectReg || periphOnchipReg;
    end
  end

  //////////////////////////////////////////////////////////////////
  // outputs
  always_comb
  begin
    ctrlState = '0;
    ctrlState.subOscEnable = subOscEnableReg;
    ctrlState.mainOscStop = mainOscStopReg;
    ctrlState.div8Select = div8SelectReg;
    ctrlState.subClockSelect = subClockSelectReg;
    ctrlState.waitPeriphClockStop = waitPeriphClockStopReg;
    ctrlState.cpuDivCode = cpuDivCodeReg;
    ctrlState.allClockStop = allClockStopReg;
    ctrlState.pllSourceSelect = pllSourceSelectReg;
    ctrlState.stopDetectEnable = stopDetectEnableReg;
    ctrlState.onchipOscSelect = onchipOscSelectReg;
    ctrlState.stopDetectedFlag = stopDetectedReg;
    ctrlState.detectActionSelect = detectActionReg;
    ctrlState.pllCtrlEnable = pllCtrlEnableReg;
    ctrlState.clockModLock = clockModLockReg;
  end

  // oscillators stop with the stop mode
  assign subOscRun = subOscEnableReg && pwrReg != PWR_STOP;
  assign mainOscRun = !mainOscStopReg && pwrReg != PWR_STOP;
  assign pwrState = pwrReg;
  assign mainStoppedFlag = mainStoppedReg;
  assign oscStopIrq = irqPulseReg;
  assign sharedIrq = irqPulseReg || watchdogIrq;
  assign oscStopReset = haltReg;
endmodule

// [clock_select_osc_stop_detect_monitor.sv]
// Purpose: port checker for the clock select block
// Assumes: one clock, async active-low reset
// Notes: bound to the top module at the foot
`timescale 1ns/10ps
module clock_select_osc_stop_detect_monitor
#(
  parameter int WINDOW_CYC = clk_ctrl_pkg::DETECT_WINDOW_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // inputs
  input wire logic ctrlWrite,
  input wire clk_ctrl_pkg::clk_ctrl_s ctrlData,
  input wire logic waitInstr,
  input wire logic hwInterrupt,
  input wire logic watchdogIrq,
  // outputs
  input wire clk_ctrl_pkg::clk_ctrl_s ctrlState,
  input wire clk_ctrl_pkg::clk_sel_s clkSel,
  input wire logic subOscRun,
  input wire logic mainOscRun,
  input wire clk_ctrl_pkg::pwr_state_e pwrState,
  input wire logic sharedIrq,
  input wire logic oscStopIrq,
  input wire logic oscStopReset
);
  import clk_ctrl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  function automatic logic [4:0] ratio_of(input logic d8, input logic [1:0] c);
    return d8 ? DIV_RATIO_8 : c == DIV_CODE_1 ? DIV_RATIO_1 : c == DIV_CODE_2 ? DIV_RATIO_2
      : c == DIV_CODE_4 ? DIV_RATIO_4 : DIV_RATIO_16;
  endfunction
  ////////////////////////////////////////////////////////////////
  a_div_ratio:
    assert property (clkSel.cpuDivRatio == ratio_of($past(ctrlState.div8Select),
      $past(ctrlState.cpuDivCode))) else $error("cpu divide ratio wrong");
  a_sub_run:
    assert property (pwrState == PWR_RUN |-> subOscRun == ctrlState.subOscEnable)
      else $error("sub osc run wrong");
  a_main_run:
    assert property (pwrState == PWR_RUN |-> mainOscRun != ctrlState.mainOscStop)
      else $error("main osc run wrong");
  a_sub_pick:
    assert property (ctrlState.subClockSelect |=> clkSel.cpuSource == SRC_SUB)
      else $error("sub clock not picked");
  a_pll_pick:
    assert property (!ctrlState.subClockSelect && !ctrlState.onchipOscSelect
      && ctrlState.pllCtrlEnable && ctrlState.pllSourceSelect |=> clkSel.cpuSource == SRC_PLL)
      else $error("pll not picked");
  a_stop_entry:
    assert property (ctrlWrite && ctrlData.allClockStop && !ctrlState.clockModLock
      && !hwInterrupt && pwrState == PWR_RUN |=> pwrState == PWR_STOP)
      else $error("stop not entered");
  a_wait_entry:
    assert property (waitInstr && !ctrlWrite && !hwInterrupt && pwrState == PWR_RUN
      |=> pwrState == PWR_WAIT) else $error("wait not entered");
  a_lock_hold:
    assert property (ctrlWrite && ctrlState.clockModLock |=> $stable({ctrlState.mainOscStop,
      ctrlState.subClockSelect, ctrlState.waitPeriphClockStop, ctrlState.pllSourceSelect,
      ctrlState.stopDetectEnable, ctrlState.pllCtrlEnable})) else $error("locked bit changed");
  a_irq_share:
    assert property (sharedIrq == (oscStopIrq || watchdogIrq)) else $error("shared irq wrong");
  a_irq_flag:
    assert property (oscStopIrq |-> ctrlState.stopDetectedFlag ##1 !oscStopIrq)
      else $error("irq without flag or too long");
  a_reset_sticky:
    assert property ($rose(oscStopReset) |=> oscStopReset [*8])
      else $error("stop reset released");
  c_stop: cover property (pwrState == PWR_STOP);
  c_irq: cover property (oscStopIrq);
  c_rst: cover property (oscStopReset);
endmodule
bind clock_select_osc_stop_detect clock_select_osc_stop_detect_monitor
  #(.WINDOW_CYC(WINDOW_CYC)) monitor_i (.core_clk(core_clk), .rst_b(rst_b),
  .ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .waitInstr(waitInstr),
  .hwInterrupt(hwInterrupt), .watchdogIrq(watchdogIrq), .ctrlState(ctrlState),
  .clkSel(clkSel), .subOscRun(subOscRun), .mainOscRun(mainOscRun), .pwrState(pwrState),
  .sharedIrq(sharedIrq), .oscStopIrq(oscStopIrq), .oscStopReset(oscStopReset));

// [test_clock_select_osc_stop_detect.sv]
// Purpose: directed bench for the clock select block
// Assumes: short detect window of 8 cycles
// Notes: main oscillator modelled as a toggling sample
`timescale 1ns/10ps
module test_clock_select_osc_stop_detect;
  import clk_ctrl_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ctrlWrite = 1'b0;
  clk_ctrl_s ctrlData = '0;
  logic lockWrite = 1'b0;
  logic waitInstr = 1'b0;
  logic hwInterrupt = 1'b0;
  logic mainClkSample = 1'b0;
  logic watchdogIrq = 1'b0;
  clk_ctrl_s ctrlState;
  clk_sel_s clkSel;
  logic subOscRun;
  logic mainOscRun;
  pwr_state_e pwrState;
  logic mainStoppedFlag;
  logic sharedIrq;
  logic oscStopIrq;
  logic oscStopReset;
  clk_ctrl_s cfg;
  bit mainOn = 1'b1;
  bit seen;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  clock_select_osc_stop_detect #(.WINDOW_CYC(8)) clock_select_osc_stop_detect_i
    (.core_clk(core_clk), .rst_b(rst_b), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData),
    .lockWrite(lockWrite), .waitInstr(waitInstr), .hwInterrupt(hwInterrupt),
    .mainClkSample(mainClkSample), .watchdogIrq(watchdogIrq), .ctrlState(ctrlState),
    .clkSel(clkSel), .subOscRun(subOscRun), .mainOscRun(mainOscRun), .pwrState(pwrState),
    .mainStoppedFlag(mainStoppedFlag), .sharedIrq(sharedIrq), .oscStopIrq(oscStopIrq),
    .oscStopReset(oscStopReset));
  ////////////////////////////////////////////////////////////////
  initial
  forever #5 core_clk = ~core_clk;
  // a fast main clock: one toggle per core cycle
  always @(negedge core_clk)
    if (mainOn)
      mainClkSample <= ~mainClkSample;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [4:0] got, input logic [4:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    cfg = '0;
    cfg.div8Select = 1'b1;
    mainOn = 1'b1;
    tick(4);
    rst_b = 1'b1;
  endtask
  // whole-struct write; detected flag always written 0, which clears it
  task automatic wr();
    ctrlData = cfg;
    ctrlWrite = 1'b1;
    tick(1);
    ctrlWrite = 1'b0;
    tick(2);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  task automatic wait_irq(input int lim);
    seen = 1'b0;
    while (!seen && lim > 0)
    begin
      @(posedge core_clk);
      #1;
      seen = (oscStopIrq === 1'b1) && (sharedIrq === 1'b1);
      lim--;
    end
    // clkSel trails the flags by one edge; let it settle before looking
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_div();
    logic [4:0] exp [4] = '{DIV_RATIO_1, DIV_RATIO_2, DIV_RATIO_4, DIV_RATIO_16};
    check(clkSel.cpuDivRatio, DIV_RATIO_8, "reset ratio");
    cfg.div8Select = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      cfg.cpuDivCode = 2'(i);
      wr();
      check(clkSel.cpuDivRatio, exp[i], "div code");
    end
    $display("test div done");
  endtask
  task automatic t_src();
    cfg.subOscEnable = 1'b1;
    cfg.subClockSelect = 1'b1;
    wr();
    check({subOscRun, clkSel.cpuSource}, {1'b1, SRC_SUB}, "sub pick");
    cfg.subClockSelect = 1'b0;
    cfg.onchipOscSelect = 1'b1;
    wr();
    check(clkSel.cpuSource, SRC_ONCHIP, "onchip pick");
    cfg.onchipOscSelect = 1'b0;
    cfg.pllCtrlEnable = 1'b1;
    cfg.pllSourceSelect = 1'b1;
    wr();
    check(clkSel.cpuSource, SRC_PLL, "pll pick");
    {cfg.pllCtrlEnable, cfg.pllSourceSelect, cfg.subOscEnable, cfg.mainOscStop} = 4'h1;
    wr();
    check({clkSel.cpuSource, mainOscRun, subOscRun}, {SRC_MAIN, 2'b00}, "main off");
    cfg.mainOscStop = 1'b0;
    wr();
    check(mainOscRun, 1'b1, "main on");
    $display("test src done");
  endtask
  task automatic t_power();
    cfg.allClockStop = 1'b1;
    wr();
    cfg.allClockStop = 1'b0;
    check({pwrState, mainOscRun}, {PWR_STOP, 1'b0}, "stop entry");
    pulse(hwInterrupt);
    check({pwrState, ctrlState.div8Select}, {PWR_RUN, 1'b1}, "stop exit");
    pulse(waitInstr);
    check(pwrState, PWR_WAIT, "wait entry");
    pulse(hwInterrupt);
    check(pwrState, PWR_RUN, "wait exit");
    $display("test power done");
  endtask
  task automatic t_lock();
    cfg.clockModLock = 1'b1;
    ctrlData = cfg;
    pulse(lockWrite);
    {cfg.mainOscStop, cfg.subClockSelect, cfg.waitPeriphClockStop, cfg.pllSourceSelect,
      cfg.stopDetectEnable, cfg.pllCtrlEnable, cfg.allClockStop, cfg.subOscEnable} = 8'hFF;
    wr();
    check({ctrlState.mainOscStop, ctrlState.subClockSelect, ctrlState.waitPeriphClockStop,
      ctrlState.pllSourceSelect, ctrlState.stopDetectEnable}, 5'h00, "locked bits");
    check({ctrlState.pllCtrlEnable, pwrState, subOscRun}, {1'b0, PWR_RUN, 1'b1}, "lock");
    $display("test lock done");
  endtask
  task automatic t_detect();
    do_reset();
    {cfg.detectActionSelect, cfg.stopDetectEnable} = 2'h3;
    wr();
    mainOn = 1'b0;
    wait_irq(40);
    check({seen, ctrlState.onchipOscSelect, ctrlState.stopDetectedFlag, mainStoppedFlag},
      4'hF, "stop event");
    check({clkSel.cpuSource, clkSel.periphSource, clkSel.onchipOscRun},
      {SRC_ONCHIP, SRC_ONCHIP, 1'b1}, "moved onchip");
    cfg.onchipOscSelect = 1'b1;
    wr();
    check(ctrlState.stopDetectedFlag, 1'b0, "flag clear");
    mainOn = 1'b1;
    wait_irq(40);
    check({seen, ctrlState.stopDetectedFlag, mainStoppedFlag, ctrlState.onchipOscSelect},
      4'hD, "restart");
    mainOn = 1'b0;
    wait_irq(40);
    check(seen, 1'b0, "masked");
    watchdogIrq = 1'b1;
    tick(1);
    check(sharedIrq, 1'b1, "watchdog");
    watchdogIrq = 1'b0;
    cfg.waitPeriphClockStop = 1'b0;
    wr();
    pulse(waitInstr);
    check({ctrlState.waitPeriphClockStop, pwrState}, {1'b0, PWR_WAIT}, "wait detect");
    pulse(hwInterrupt);
    $display("test detect done");
  endtask
  task automatic t_fallback();
    do_reset();
    {cfg.subOscEnable, cfg.subClockSelect, cfg.detectActionSelect,
      cfg.stopDetectEnable} = 4'hF;
    wr();
    mainOn = 1'b0;
    wait_irq(40);
    check({seen, ctrlState.onchipOscSelect, clkSel.onchipOscRun}, 3'h5,
      "low speed flags");
    check({clkSel.cpuSource, clkSel.periphSource}, {SRC_SUB, SRC_ONCHIP},
      "low speed");
    do_reset();
    {cfg.pllCtrlEnable, cfg.pllSourceSelect, cfg.detectActionSelect,
      cfg.stopDetectEnable} = 4'hF;
    wr();
    mainOn = 1'b0;
    wait_irq(40);
    check({seen, ctrlState.onchipOscSelect, ctrlState.stopDetectedFlag, mainStoppedFlag},
      4'hB, "pll stop");
    check({clkSel.cpuSource, clkSel.periphSource}, {SRC_PLL, SRC_PLL},
      "pll kept");
    $display("test fallback done");
  endtask
  task automatic t_rst_mode();
    do_reset();
    cfg.stopDetectEnable = 1'b1;
    wr();
    mainOn = 1'b0;
    for (int i = 0; i < 40 && oscStopReset !== 1'b1; i++)
      tick(1);
    mainOn = 1'b1;
    tick(20);
    check({oscStopReset, oscStopIrq}, 2'b10, "stop reset held");
    do_reset();
    check(oscStopReset, 1'b0, "hw reset clears");
    $display("test reset mode done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    t_div();
    t_src();
    t_power();
    t_lock();
    t_detect();
    t_fallback();
    t_rst_mode();
    wrap_up();
  end
endmodule
